// ==== logic/gpib_core.v ====
// Purpose: device-side bus interface functions, talker and listener
// Assumes: lines given as true-asserted logic levels; pad inverts
// Notes: open-collector lines: oe low drives the out level; only a true level pulls the line
`timescale 1ns/1ps
`default_nettype none
`include "gpib_defines.vh"
module gpib_core #(
  parameter SETTLE_CYC = `GPIB_SETTLE_CYC
) (
  input wire clock,
  input wire reset_n,
  input wire [4:0] myAddress,
  input wire talkOnly,
  input wire [7:0] dioIn,
  input wire atnIn,
  input wire davIn,
  input wire nrfdIn,
  input wire ndacIn,
  input wire eoiIn,
  input wire renIn,
  input wire ifcIn,
  output reg [7:0] dioOut,
  output reg [7:0] dioOe_n,
  output reg davOut,
  output reg davOe_n,
  output reg nrfdOut,
  output reg nrfdOe_n,
  output reg ndacOut,
  output reg ndacOe_n,
  output reg eoiOut,
  output reg eoiOe_n,
  output reg srqOut,
  output reg srqOe_n,
  input wire [7:0] txData,
  input wire txLast,
  input wire txValid,
  output reg txReady,
  output reg [7:0] rxData,
  output reg rxLast,
  output reg rxValid,
  input wire [6:0] statusByte,
  input wire serviceWanted,
  output reg talkerActive,
  output reg listenerActive,
  output reg remoteMode,
  output reg lockoutMode,
  output reg devClear,
  output reg devTrigger
);
  localparam AH_IDLE = 2'h0;
  localparam AH_READY = 2'h1;
  localparam AH_ACCEPT = 2'h2;
  localparam AH_WAIT = 2'h3;
  localparam SH_IDLE = 2'h0;
  localparam SH_SETTLE = 2'h1;
  localparam SH_VALID = 2'h2;
  localparam SH_DONE = 2'h3;
  wire [12:0] pinSync;
  wire [7:0] dio;
  wire atn, dav, nrfd, ndac, eoi, ren, ifc;
  gpib_sync #(.WIDTH(13)) uSync (
    .clock(clock),
    .reset_n(reset_n),
    .asyncIn({dioIn, atnIn, davIn, nrfdIn, ndacIn, eoiIn}),
    .syncOut(pinSync)
  );
  assign {dio, atn, dav, nrfd, ndac, eoi} = pinSync;
  reg [1:0] renIfc1_q, renIfc_q;
  assign ren = renIfc_q[1];
  assign ifc = renIfc_q[0];
  reg [1:0] ahState_q;
  reg [1:0] shState_q;
  reg [15:0] settle_q;
  reg [7:0] heldByte_q;
  reg heldLast_q, heldSpoll_q;
  reg talk_q, listen_q, spollMode_q, rqs_q, srqReq_q;
  reg [7:0] shByte_q;
  reg shEoi_q;
  function grpIs;
    input [7:0] b;
    input [1:0] g;
    begin
      grpIs = (b[`GPIB_GRP_MSB:`GPIB_GRP_LSB] == g);
    end
  endfunction
  wire accepted = (ahState_q == AH_ACCEPT);
  wire cmdByte = accepted && atn;
  wire dataByte = accepted && !atn;
  wire canTalk = (talk_q || talkOnly) && !atn;
  wire [6:0] cmd = heldByte_q[6:0];
  // ------------------------------------------------
  // remote enable and clear synchronisers
  // ------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      renIfc1_q <= 2'h0;
      renIfc_q <= 2'h0;
    end else begin
      renIfc1_q <= {renIn, ifcIn};
      renIfc_q <= renIfc1_q;
    end
  end
  // ------------------------------------------------
  // acceptor handshake
  // ------------------------------------------------
  // commands are always taken under attention; data only when listening
  always @(posedge clock) begin
    if (!reset_n || ifc) begin
      ahState_q <= AH_IDLE;
      heldByte_q <= 8'h00;
      heldLast_q <= 1'b0;
    end else begin
      case (ahState_q)
        AH_IDLE: if (atn || (listen_q && !rxValid)) begin
          ahState_q <= AH_READY;
        end
        AH_READY: if (dav) begin
          heldByte_q <= dio;
          heldLast_q <= eoi;
          ahState_q <= AH_ACCEPT;
        end else if (!atn && !listen_q) begin
          ahState_q <= AH_IDLE;
        end
        AH_ACCEPT: ahState_q <= AH_WAIT;
        AH_WAIT: if (!dav) begin
          ahState_q <= AH_IDLE;
        end
        default: ahState_q <= AH_IDLE;
      endcase
    end
  end
  // ------------------------------------------------
  // addressing and command decode
  // ------------------------------------------------
  wire isLag = grpIs(heldByte_q, `GPIB_GRP_LAG) && cmd != `GPIB_CMD_UNL;
  wire isTag = grpIs(heldByte_q, `GPIB_GRP_TAG) && cmd != `GPIB_CMD_UNT;
  wire mine = heldByte_q[4:0] == myAddress;
  always @(posedge clock) begin
    if (!reset_n || ifc) begin
      talk_q <= 1'b0;
      listen_q <= 1'b0;
      spollMode_q <= 1'b0;
      devClear <= 1'b0;
      devTrigger <= 1'b0;
    end else begin
      devClear <= 1'b0;
      devTrigger <= 1'b0;
      if (cmdByte) begin
        // secondary group bytes fall through every branch
        if (isLag && mine) begin
          listen_q <= 1'b1;
        end else if (cmd == `GPIB_CMD_UNL) begin
          listen_q <= 1'b0;
        end else if (isTag && !mine) begin
          listen_q <= 1'b0;
        end
        if (isTag && mine) begin
          talk_q <= 1'b1;
        end else if (cmd == `GPIB_CMD_UNT || isTag) begin
          talk_q <= 1'b0;
        end else if (isLag && !mine) begin
          talk_q <= 1'b0;
        end
        if (cmd == `GPIB_CMD_SPE) spollMode_q <= 1'b1;
        if (cmd == `GPIB_CMD_SPD) spollMode_q <= 1'b0;
        if (cmd == `GPIB_CMD_DCL || (cmd == `GPIB_CMD_SDC && listen_q)) begin
          devClear <= 1'b1;
          spollMode_q <= 1'b0;
        end
        if (cmd == `GPIB_CMD_GET && listen_q) devTrigger <= 1'b1;
      end
    end
  end
  // ------------------------------------------------
  // remote and local
  // ------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      remoteMode <= 1'b0;
      lockoutMode <= 1'b0;
    end else if (!ren) begin
      remoteMode <= 1'b0;
      lockoutMode <= 1'b0;
    end else if (cmdByte && isLag && mine) begin
      remoteMode <= 1'b1;
    end else if (cmdByte && cmd == `GPIB_CMD_GTL && listen_q) begin
      remoteMode <= 1'b0;
    end else if (cmdByte && cmd == `GPIB_CMD_LLO) begin
      lockoutMode <= 1'b1;
    end
  end
  // ------------------------------------------------
  // service request, held until polled or cleared
  // ------------------------------------------------
  wire polledOut = (shState_q == SH_DONE) && heldSpoll_q;
  always @(posedge clock) begin
    if (!reset_n || ifc || devClear) begin
      rqs_q <= 1'b0;
    end else if (serviceWanted && !rqs_q) begin
      rqs_q <= 1'b1;
    end else if (polledOut) begin
      rqs_q <= 1'b0;
    end
  end
  // ------------------------------------------------
  // source handshake
  // ------------------------------------------------
  wire haveByte = spollMode_q ? 1'b1 : txValid;
  always @(posedge clock) begin
    if (!reset_n || ifc || devClear) begin
      shState_q <= SH_IDLE;
      settle_q <= 16'h0000;
      shByte_q <= 8'h00;
      shEoi_q <= 1'b0;
      heldSpoll_q <= 1'b0;
      txReady <= 1'b0;
    end else begin
      txReady <= 1'b0;
      case (shState_q)
        SH_IDLE: if (canTalk && haveByte && !txReady) begin
          shByte_q <= spollMode_q ? {statusByte[6], rqs_q,
            statusByte[5:0]} : txData;
          shEoi_q <= spollMode_q ? 1'b0 : txLast;
          heldSpoll_q <= spollMode_q;
          txReady <= !spollMode_q;
          settle_q <= SETTLE_CYC[15:0];
          shState_q <= SH_SETTLE;
        end
        SH_SETTLE: if (!canTalk) begin
          shState_q <= SH_IDLE;
        end else if (settle_q > 16'h0001) begin
          settle_q <= settle_q - 16'h0001;
        end else if (!nrfd) begin
          shState_q <= SH_VALID;
        end
        SH_VALID: if (!ndac) shState_q <= SH_DONE;
        SH_DONE: shState_q <= SH_IDLE;
        default: shState_q <= SH_IDLE;
      endcase
    end
  end
  // ------------------------------------------------
  // received data stream
  // ------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n || ifc) begin
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxLast <= 1'b0;
    end else if (dataByte && listen_q) begin
      rxValid <= 1'b1;
      rxData <= heldByte_q;
      rxLast <= heldLast_q;
    end else begin
      rxValid <= 1'b0;
    end
  end
  // ------------------------------------------------
  // pin drivers; attention and clear have no driver at all
  // ------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      dioOut <= 8'h00;
      dioOe_n <= 8'hFF;
      davOut <= 1'b0;
      davOe_n <= 1'b1;
      nrfdOut <= 1'b0;
      nrfdOe_n <= 1'b1;
      ndacOut <= 1'b0;
      ndacOe_n <= 1'b1;
      eoiOut <= 1'b0;
      eoiOe_n <= 1'b1;
      srqOut <= 1'b0;
      srqOe_n <= 1'b1;
      talkerActive <= 1'b0;
      listenerActive <= 1'b0;
    end else begin
      // data lines only carry talker bytes; a poll under attention never
      dioOut <= shByte_q;
      dioOe_n <= (shState_q != SH_IDLE && canTalk) ? 8'h00 : 8'hFF;
      davOut <= (shState_q == SH_VALID);
      davOe_n <= !(shState_q == SH_VALID);
      eoiOut <= shEoi_q;
      eoiOe_n <= !(shEoi_q && shState_q != SH_IDLE && canTalk);
      nrfdOut <= (ahState_q != AH_READY);
      nrfdOe_n <= !(ahState_q != AH_READY && (atn || listen_q));
      ndacOut <= (ahState_q != AH_WAIT);
      ndacOe_n <= !(ahState_q != AH_WAIT && (atn || listen_q));
      srqOut <= rqs_q && !polledOut;
      srqOe_n <= !(rqs_q && !polledOut);
      talkerActive <= talk_q || talkOnly;
      listenerActive <= listen_q;
    end
  end
endmodule
`default_nettype wire

// ==== logic/gpib_defines.vh ====
// Purpose: constants for the instrument bus interface functions
// Assumes: 50 MHz clock, bus lines already synchronised in the core
// Notes: Notes on behaviour below
//
// Notes on behaviour
// - source handshake drives bytes onto bus
// - acceptor handshake receives bytes under attention or while listening
// - talk only while talker addressed or talk-only set
// - talk, talk-only and serial poll status
// - other listen address unaddresses talker
// - accept data only while listener addressed
// - other talk address unaddresses listener
// - assert service request on enabled condition
// - remote and local states under bus control
// - never drive a parallel poll response
// - device clear reinitialises service request, serial poll and source handshake
// - trigger reading when addressed and triggered
// - no controller: never drive attention or clear
// - primary addressing only, secondaries ignored
`ifndef GPIB_DEFINES_VH
`define GPIB_DEFINES_VH
// ------------------------------------------------
// command codes, low seven bits, attention true
// ------------------------------------------------
`define GPIB_CMD_GTL 7'h01
`define GPIB_CMD_SDC 7'h04
`define GPIB_CMD_GET 7'h08
`define GPIB_CMD_LLO 7'h11
`define GPIB_CMD_DCL 7'h14
`define GPIB_CMD_SPE 7'h18
`define GPIB_CMD_SPD 7'h19
`define GPIB_CMD_UNL 7'h3F
`define GPIB_CMD_UNT 7'h5F
// ------------------------------------------------
// address groups and fields
// ------------------------------------------------
`define GPIB_GRP_LAG 2'h1
`define GPIB_GRP_TAG 2'h2
`define GPIB_GRP_SCG 2'h3
`define GPIB_GRP_MSB 6
`define GPIB_GRP_LSB 5
`define GPIB_RQS_BIT 6
// ------------------------------------------------
// timing
// ------------------------------------------------
`define GPIB_CLK_MHZ 50
`define GPIB_SETTLE_NS 2000
`define GPIB_SETTLE_CYC ((`GPIB_SETTLE_NS * `GPIB_CLK_MHZ + 999) / 1000)
`endif

// ==== logic/gpib_sync.v ====
// Purpose: two-flop synchroniser for a vector of bus pins
// Assumes: inputs asynchronous to clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module gpib_sync #(
  parameter WIDTH = 13
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_q;
  // ------------------------------------------------
  // idle bus lines are false, so reset to zero
  // ------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      stage1_q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ieee488_instrument_interface_functions_bench.sv ====
// Purpose: self-checking run of the instrument bus core
// Assumes: controller model on the far side, address 10h
// Notes: short settle count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
`include "gpib_defines.vh"
module ieee488_instrument_interface_functions_bench;
  // --------
  // wiring
  // --------
  logic clock = 0, reset_n = 0, talkOnly = 0, ifcIn = 0;
  logic [4:0] myAddress = 5'h10;
  logic [7:0] dioIn, dioOut, dioOe_n, rxData, b, d;
  logic [7:0] txData = 8'h00;
  logic atnIn, davIn, nrfdIn, ndacIn, eoiIn, renIn, e;
  logic davOut, davOe_n, nrfdOut, nrfdOe_n, ndacOut, ndacOe_n;
  logic eoiOut, eoiOe_n, srqOut, srqOe_n, txReady, rxLast, rxValid;
  logic txLast = 0, txValid = 0, serviceWanted = 0;
  logic [6:0] statusByte = 7'h00;
  logic talkerActive, listenerActive, remoteMode, lockoutMode;
  logic devClear, devTrigger;
  int n_errors = 0, total_checks = 0, nTrig = 0, nClr = 0, i, k;
  logic [7:0] expQ[$];
  logic expL[$];
  gpib_core #(.SETTLE_CYC(2)) dut (.*);
  iiif_ctrl_model ctl (.*);
  initial forever #10 clock = ~clock;
  task check(input string w, input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, x, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task guard;
    if (ctl.hang || k == 400) begin
      check("handshake", 8'h00, 8'h01);
      results();
    end
  endtask
  task bus(input logic a, input logic [7:0] v, input logic l);
    ctl.put(a, v, l);
    guard();
  endtask
  task settle;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task talk(input logic [7:0] t, input logic l);
    fork
      begin
        txData = t;
        txLast = l;
        txValid = 1;
        for (k = 0; k < 400 && txReady !== 1'b1; k++) begin
          @(posedge clock);
          #1;
        end
        txValid = 0;
      end
      ctl.get(d, e);
    join
    guard();
    check("talk byte", d, t);
    check("talk end", e, l);
  endtask
  always @(posedge clock) begin
    nTrig <= nTrig + devTrigger;
    nClr <= nClr + devClear;
    if (rxValid === 1'b1) begin
      if (expQ.size() == 0) check("rx unasked", 8'h01, 8'h00);
      else begin
        check("rxData", rxData, expQ.pop_front());
        check("rxLast", rxLast, expL.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'h77CF));
    repeat (16) @(posedge clock);
    #1 reset_n = 1;
    settle();
    ctl.ren = 1;
    bus(1, {1'b0, `GPIB_CMD_UNL}, 0);
    bus(1, 8'h30, 0);
    settle();
    check("listen", listenerActive, 1);
    check("remote", remoteMode, 1);
    for (i = 0; i < 4; i++) begin
      b = $urandom;
      expQ.push_back(b);
      expL.push_back(i == 3);
      bus(0, b, i == 3);
    end
    bus(1, {1'b0, `GPIB_CMD_GET}, 0);
    bus(1, 8'h70, 0);
    bus(1, {1'b0, `GPIB_CMD_SDC}, 0);
    settle();
    check("rx drained", expQ.size(), 0);
    check("trigger", nTrig, 1);
    check("clear", nClr, 1);
    check("secondary", talkerActive, 0);
    bus(1, 8'h45, 0);
    settle();
    check("unlisten", listenerActive, 0);
    bus(0, 8'hA5, 0);
    bus(1, {1'b0, `GPIB_CMD_GET}, 0);
    settle();
    check("trig unlistened", nTrig, 1);
    $display("test listen done");
    bus(1, 8'h50, 0);
    settle();
    check("talker", talkerActive, 1);
    for (i = 0; i < 3; i++) talk($urandom, i == 2);
    bus(1, 8'h25, 0);
    settle();
    check("untalk", talkerActive, 0);
    talkOnly = 1;
    talk(8'h3C, 1);
    talkOnly = 0;
    $display("test talk done");
    statusByte = $urandom;
    serviceWanted = 1;
    settle();
    check("srq on", srqOe_n, 0);
    check("srq level", srqOut, 1);
    bus(1, {1'b0, `GPIB_CMD_SPE}, 0);
    bus(1, 8'h50, 0);
    ctl.get(d, e);
    guard();
    check("poll rqs", d[6], 1);
    check("poll status", d[5:0], statusByte[5:0]);
    check("poll top", d[7], statusByte[6]);
    serviceWanted = 0;
    bus(1, {1'b0, `GPIB_CMD_SPD}, 0);
    bus(1, {1'b0, `GPIB_CMD_UNT}, 0);
    settle();
    check("srq off", srqOe_n, 1);
    ctl.atn = 1;
    ctl.cEoi = 1;
    settle();
    check("no ppoll", dioOe_n, 8'hFF);
    ctl.cEoi = 0;
    bus(1, {1'b0, `GPIB_CMD_DCL}, 0);
    bus(1, 8'h30, 0);
    bus(1, {1'b0, `GPIB_CMD_GTL}, 0);
    settle();
    check("go local", remoteMode, 0);
    bus(1, {1'b0, `GPIB_CMD_LLO}, 0);
    bus(1, 8'h30, 0);
    settle();
    check("lockout", lockoutMode, 1);
    check("remote again", remoteMode, 1);
    ifcIn = 1;
    settle();
    ifcIn = 0;
    check("ifc unlisten", listenerActive, 0);
    ctl.ren = 0;
    settle();
    check("dev clear", nClr, 2);
    check("local", remoteMode, 0);
    check("lockout off", lockoutMode, 0);
    $display("test poll done");
    results();
  end
endmodule
`default_nettype wire

// ==== testbench/iiif_ctrl_model.sv ====
// Purpose: bus controller model facing the core
// Assumes: open-collector lines, released line reads false
// Notes: hang flags a handshake wait that ran out
`timescale 1ns/1ps
`default_nettype none
module iiif_ctrl_model (
  input wire logic clock,
  input wire logic [7:0] dioOut,
  input wire logic [7:0] dioOe_n,
  input wire logic davOut,
  input wire logic davOe_n,
  input wire logic nrfdOut,
  input wire logic nrfdOe_n,
  input wire logic ndacOut,
  input wire logic ndacOe_n,
  input wire logic eoiOut,
  input wire logic eoiOe_n,
  output logic [7:0] dioIn,
  output logic davIn,
  output logic nrfdIn,
  output logic ndacIn,
  output logic eoiIn,
  output logic atnIn,
  output logic renIn
);
  // --------
  // wired bus
  // --------
  logic [7:0] cDio = 8'h00;
  logic cDav = 0, cEoi = 0, cNrfd = 1, cNdac = 1;
  logic atn = 0, ren = 0, hang = 0;
  int n;
  assign dioIn = cDio | (dioOut & ~dioOe_n);
  assign davIn = cDav | (davOut & ~davOe_n);
  assign nrfdIn = cNrfd | (nrfdOut & ~nrfdOe_n);
  assign ndacIn = cNdac | (ndacOut & ~ndacOe_n);
  assign eoiIn = cEoi | (eoiOut & ~eoiOe_n);
  assign atnIn = atn;
  assign renIn = ren;
  function logic ln(input int i);
    return i == 0 ? nrfdIn : i == 1 ? ndacIn : davIn;
  endfunction
  task wt(input int i, input logic v);
    for (n = 0; n < 400 && ln(i) !== v; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == 400) hang = 1;
  endtask
  // attention only for address and command bytes
  task put(input logic a, input logic [7:0] d, input logic e);
    @(posedge clock);
    #1 atn = a;
    cDio = d;
    cEoi = e;
    cNrfd = 0;
    cNdac = 0;
    repeat (4) @(posedge clock);
    #1;
    wt(0, 0);
    cDav = 1;
    wt(1, 0);
    cDav = 0;
    cDio = 8'h00;
    cEoi = 0;
  endtask
  // slow acceptor at random, up to three cycles
  task get(output logic [7:0] d, output logic e);
    @(posedge clock);
    #1 atn = 0;
    cNrfd = 0;
    // hold not-accepted until the byte is read, else the talker runs ahead
    cNdac = 1;
    wt(2, 1);
    d = dioIn;
    e = eoiIn;
    cNrfd = 1;
    repeat ($urandom_range(3)) @(posedge clock);
    #1 cNdac = 0;
    wt(2, 0);
    cNdac = 1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/iiif_monitor.sv ====
// Purpose: port checks on the instrument bus core
// Assumes: true-asserted lines, two-flop input sync
// Notes: past terms allow for sync and register lag
`timescale 1ns/1ps
`default_nettype none
module iiif_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic atnIn,
  input wire logic davIn,
  input wire logic eoiIn,
  input wire logic renIn,
  input wire logic talkOnly,
  input wire logic serviceWanted,
  input wire logic [7:0] dioOe_n,
  input wire logic davOe_n,
  input wire logic ndacOe_n,
  input wire logic srqOe_n,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic talkerActive,
  input wire logic listenerActive,
  input wire logic remoteMode,
  input wire logic devTrigger
);
  // --------
  // checks
  // --------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  dio_talker_a: assert property (!(&dioOe_n) |-> talkerActive ||
    $past(talkerActive) || talkOnly) else $error("dio driven untalked");
  dav_talker_a: assert property (!davOe_n |-> talkerActive ||
    $past(talkerActive) || talkOnly) else $error("dav driven untalked");
  tx_talker_a: assert property (txReady |-> talkerActive ||
    talkOnly) else $error("byte taken untalked");
  ndac_hold_a: assert property ((atnIn && !davIn) [*5] |->
    !ndacOe_n) else $error("ndac not held under attention");
  rx_pulse_a: assert property (rxValid |=> !rxValid)
    else $error("rxValid longer than a cycle");
  rx_listen_a: assert property (rxValid |-> listenerActive ||
    $past(listenerActive, 3)) else $error("byte taken unlistened");
  trig_listen_a: assert property (devTrigger |-> listenerActive ||
    $past(listenerActive, 3)) else $error("trigger unlistened");
  srq_cause_a: assert property ($fell(srqOe_n) |->
    serviceWanted || $past(serviceWanted, 2)) else $error("srq uncalled");
  ren_local_a: assert property (!renIn [*5] |-> !remoteMode)
    else $error("remote without ren");
  no_ppoll_a: assert property ((atnIn && eoiIn) [*4] |->
    &dioOe_n) else $error("parallel poll answered");
  cover property (rxValid && listenerActive);
  cover property (txReady && talkerActive);
  cover property (!srqOe_n ##[1:900] srqOe_n);
endmodule
bind gpib_core iiif_monitor mon (.*);
`default_nettype wire
